// File: hdl/asp_pkg.sv
// Shared constants of the converter serial port block
package asp_pkg;
    // Register byte offsets
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] SAMPLE_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    localparam logic [3:0] RESULT_OFS = 4'hC;
    // Field positions
    localparam int MODE_LSB  = 0;
    localparam int START_BIT = 4;
    localparam int BUSY_BIT  = 0;
    localparam int VALID_BIT = 1;
    localparam int READ_BIT  = 2;
    // Reset values and encodings
    localparam logic [1:0] MODE_RST    = 2'h0;
    localparam logic [1:0] MODE_SERIAL = 2'h3;
    localparam int RES_W = 18;
    localparam logic [17:0] RESULT_RST = 18'h00000;
    // Timing
    localparam int CLK_MHZ   = 25;
    localparam int CONV_NS   = 500;
    localparam int CONV_CYC  = (CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int HALF_RAC  = 1;
    localparam int HALF_RDC  = 2;
    localparam int DAISY_LAT = 18;
endpackage : asp_pkg

// File: hdl/asp_serial_port.sv
// Converter result port: shared parallel pins, serial master and slave
//
// Behaviour
// - Interface select 0, 1 or 2 drives the shared pins as result bits 6-9.
// - Interface select 3 turns the shared pins into serial config inputs.
// - Clock source select low makes the port master, driving serial clock.
// - Clock source select high makes the port slave to an outside clock.
// - As master, frame sync is active high with polarity low, else low.
// - The clock invert input swaps which serial clock edge is active.
// - As master, read-during-conversion picks reading during or after.
// - Read-during-conversion high shifts the previous result, slower clock.
// - Read-during-conversion low waits for the conversion to complete.
// - As slave, the daisy input reappears on the output 18 clocks later.
// - As slave, data changes on the rising edge, falling when inverted.
// - As master, frame sync is asserted while serial data is valid.
// - Results leave MSB first in the coding chosen by the coding input.
`timescale 1ns/1ps
module asp_serial_port #(
    parameter int CONV_CYC = asp_pkg::CONV_CYC,
    parameter int HALF_RAC = asp_pkg::HALF_RAC,
    parameter int HALF_RDC = asp_pkg::HALF_RDC
) (
    // System
    input  wire logic        clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [3:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWritedata,
    output logic      [31:0] avsReaddata,
    output logic             avsWaitrequest,
    // Shared pins, bits 6 to 9
    input  wire logic [3:0]  parBitIn,
    output logic      [3:0]  parBitOut,
    output logic      [3:0]  parBitOeN,
    // Coding select pin
    input  wire logic        outputCodingSelect,
    // Serial link
    input  wire logic        sclkIn,
    output logic             sclkOut,
    output logic             sclkOeN,
    input  wire logic        chipSelectN,
    output logic             serialResultOutput,
    output logic             frameSync
);
    localparam int W = asp_pkg::RES_W;

    typedef enum logic {M_IDLE, M_SHIFT} asp_mstate_e;

    function automatic logic [W-1:0] encode(input logic [W-1:0] v,
                                            input logic binary);
        encode = binary ? v : {~v[W-1], v[W-2:0]};
    endfunction : encode

    logic [1:0]   mode;
    logic [W-1:0] sample;
    logic [W-1:0] result;
    logic [W-1:0] prevResult;
    logic         haveResult;
    logic         convBusy;
    logic [15:0]  convCnt;
    logic         convStart;
    logic         convDone;
    logic [3:0]   cfgMeta;
    logic [3:0]   cfg;
    logic [1:0]   codeSync;
    logic         serialMode;
    logic         masterMode;
    logic         ack;
    logic         busReq;
    asp_mstate_e  mState;
    logic [W-1:0] mShift;
    logic [4:0]   mBit;
    logic [3:0]   mHalf;
    logic         mPhase;
    logic         mSlow;
    logic         resToggle;
    logic [W-1:0] resHold;

    // Config pins only mean anything in serial mode; synchronised first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfgMeta  <= 4'h0;
            cfg      <= 4'h0;
            codeSync <= 2'h0;
        end else begin
            cfgMeta  <= parBitIn;
            cfg      <= cfgMeta;
            codeSync <= {codeSync[0], outputCodingSelect};
        end
    end

    assign serialMode = (mode == asp_pkg::MODE_SERIAL);
    assign masterMode = serialMode && !cfg[0];

    // One wait state on every access; read data stands at the release edge
    assign busReq         = avsRead || avsWrite;
    assign avsWaitrequest = busReq && !ack;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= busReq && !ack;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avsReaddata <= 32'h00000000;
        end else if (avsRead && !ack) begin
            unique case (avsAddress)
                asp_pkg::CTRL_OFS:   avsReaddata <= {30'h0, mode};
                asp_pkg::SAMPLE_OFS: avsReaddata <= {14'h0, sample};
                asp_pkg::STATUS_OFS: avsReaddata <= {29'h0,
                                         mState == M_SHIFT,
                                         haveResult, convBusy};
                asp_pkg::RESULT_OFS: avsReaddata <= {14'h0, result};
                default:             avsReaddata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode   <= asp_pkg::MODE_RST;
            sample <= asp_pkg::RESULT_RST;
        end else if (avsWrite && ack) begin
            if (avsAddress == asp_pkg::CTRL_OFS) begin
                mode <= avsWritedata[asp_pkg::MODE_LSB +: 2];
            end
            if (avsAddress == asp_pkg::SAMPLE_OFS) begin
                sample <= avsWritedata[W-1:0];
            end
        end
    end

    // A start while busy is ignored
    assign convStart = avsWrite && ack && !convBusy
                       && avsAddress == asp_pkg::CTRL_OFS
                       && avsWritedata[asp_pkg::START_BIT];
    assign convDone  = convBusy && convCnt == 16'(CONV_CYC - 1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            convBusy   <= 1'b0;
            convCnt    <= 16'h0000;
            result     <= asp_pkg::RESULT_RST;
            prevResult <= asp_pkg::RESULT_RST;
            haveResult <= 1'b0;
            resHold    <= asp_pkg::RESULT_RST;
            resToggle  <= 1'b0;
        end else begin
            if (convStart) begin
                convBusy   <= 1'b1;
                convCnt    <= 16'h0000;
                prevResult <= result;
            end else if (convDone) begin
                convBusy   <= 1'b0;
                result     <= encode(sample, codeSync[1]);
                resHold    <= encode(sample, codeSync[1]);
                resToggle  <= !resToggle;
                haveResult <= 1'b1;
            end else if (convBusy) begin
                convCnt <= convCnt + 16'h0001;
            end
        end
    end

    // Shared pins
    assign parBitOut = result[9:6];
    assign parBitOeN = serialMode ? 4'hF : 4'h0;

    // Master engine: serial clock derived from clk, no second domain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mState <= M_IDLE;
            mShift <= asp_pkg::RESULT_RST;
            mBit   <= 5'h00;
            mHalf  <= 4'h0;
            mPhase <= 1'b0;
            mSlow  <= 1'b0;
        end else if (!masterMode) begin
            mState <= M_IDLE;
            mPhase <= 1'b0;
        end else begin
            unique case (mState)
                M_IDLE: begin
                    mBit   <= 5'h00;
                    mHalf  <= 4'h0;
                    mPhase <= 1'b0;
                    if (cfg[3] && convStart && haveResult) begin
                        mState <= M_SHIFT;
                        mShift <= result;
                        mSlow  <= 1'b1;
                    end else if (!cfg[3] && convDone) begin
                        mState <= M_SHIFT;
                        mShift <= encode(sample, codeSync[1]);
                        mSlow  <= 1'b0;
                    end
                end
                M_SHIFT: begin
                    // Slower clock while converting keeps the core quiet
                    if (mHalf == 4'(mSlow ? HALF_RDC - 1 : HALF_RAC - 1))
                    begin
                        mHalf  <= 4'h0;
                        mPhase <= !mPhase;
                        if (mPhase) begin
                            mShift <= {mShift[W-2:0], 1'b0};
                            mBit   <= mBit + 5'h01;
                            if (mBit == 5'(W - 1)) begin
                                mState <= M_IDLE;
                            end
                        end
                    end else begin
                        mHalf <= mHalf + 4'h1;
                    end
                end
            endcase
        end
    end

    assign sclkOut = mPhase ^ cfg[2];
    assign sclkOeN = !masterMode;
    assign frameSync = (mState == M_SHIFT) ^ cfg[1];

    // Slave engine on the host clock; invert pin is a static strap, so it
    // picks the edge directly at the cost of a glitch if changed mid-frame
    logic         linkClk;
    logic [W-1:0] sShift;
    logic [W-1:0] sWord;
    logic [4:0]   sCnt;
    logic [2:0]   sTog;
    logic [1:0]   sSlave;

    assign linkClk = sclkIn ^ parBitIn[2];

    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            sTog   <= 3'h0;
            sSlave <= 2'h0;
            sWord  <= asp_pkg::RESULT_RST;
        end else begin
            sTog   <= {sTog[1:0], resToggle};
            sSlave <= {sSlave[0], serialMode && cfg[0]};
            // Word was stable two edges before the toggle arrives
            if (sTog[2] != sTog[1]) begin
                sWord <= resHold;
            end
        end
    end

    // Counter clears only on edges with chip select high or slave mode off, so idle needs an edge
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            sShift <= asp_pkg::RESULT_RST;
            sCnt   <= 5'h00;
        end else if (chipSelectN || !sSlave[1]) begin
            sCnt <= 5'h00;
        end else if (sCnt == 5'h00) begin
            sShift <= sWord;
            sCnt   <= 5'h01;
        end else begin
            sShift <= {sShift[W-2:0], parBitIn[3]};
            if (sCnt != 5'h1F) begin
                sCnt <= sCnt + 5'h01;
            end
        end
    end

    assign serialResultOutput = masterMode ? mShift[W-1] : sShift[W-1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_par_drive: assert property (
        !serialMode |-> parBitOeN == 4'h0 && parBitOut == result[9:6])
        else $error("shared pins not driven in parallel mode");
    chk_cfg_inputs: assert property (
        serialMode |-> parBitOeN == 4'hF)
        else $error("shared pins driven in serial mode");
    chk_master_clock: assert property (
        masterMode && mState == M_IDLE |-> !sclkOeN && sclkOut == cfg[2])
        else $error("master clock not driven at idle level");
    chk_slave_release: assert property (
        serialMode && cfg[0] |-> sclkOeN && mState == M_IDLE)
        else $error("slave mode drives the serial clock");
    chk_sync_level: assert property (
        masterMode && cfg[1] && mState == M_SHIFT |-> !frameSync)
        else $error("inverted frame sync not low during frame");
    chk_wait_done: assert property (
        masterMode && !cfg[3] && mState == M_IDLE && !convDone
        |=> mState == M_IDLE)
        else $error("read after convert started early");
    chk_during_start: assert property (
        masterMode && $stable(cfg) && cfg[3] && mState == M_IDLE
        && convStart && haveResult |=> mState == M_SHIFT && mSlow
        && mShift == $past(result))
        else $error("read during conversion did not start");
    chk_msb_first: assert property (
        masterMode && mState == M_IDLE && !cfg[3] && convDone
        |=> serialResultOutput == $past(encode(sample, codeSync[1]) >> 17))
        else $error("first serial bit is not the result MSB");
    chk_frame_hold: assert property (
        masterMode && $rose(mState == M_SHIFT) && !mSlow
        |-> (frameSync != cfg[1])[*8])
        else $error("frame sync dropped during data");
    chk_slave_load: assert property (
        @(posedge linkClk) disable iff (rst)
        !chipSelectN && sSlave[1] && sCnt == 5'h00 |=> sShift == $past(sWord))
        else $error("slave word not loaded on first edge");
    chk_daisy_path: assert property (
        @(posedge linkClk) disable iff (rst)
        !chipSelectN && sSlave[1] && sCnt != 5'h00
        |=> sShift[0] == $past(parBitIn[3]))
        else $error("daisy input not shifted in");

    cov_rac_frame: cover property (
        masterMode && !cfg[3] && $fell(mState == M_SHIFT));
    cov_rdc_frame: cover property (
        masterMode && mSlow && $fell(mState == M_SHIFT));
    cov_slave_daisy: cover property (
        @(posedge linkClk) disable iff (rst)
        sCnt == 5'(asp_pkg::DAISY_LAT + 1));
endmodule : asp_serial_port

// File: tb/asp_host_model.sv
// Host side of the link: captures master frames, clocks slave frames
`timescale 1ns/1ps
module asp_host_model (
    // System
    input  wire logic        clk,
    input  wire logic        rst,
    // Host view of the strap pins
    input  wire logic        pol,
    input  wire logic        inv,
    input  wire logic        slvGo,
    // Link
    input  wire logic        sclkOut,
    input  wire logic        frameSync,
    input  wire logic        serialResultOutput,
    output logic             sclkIn,
    output logic             chipSelectN,
    // Captured frame
    output logic             linkDone,
    output logic      [31:0] linkVal
);
    logic        act;
    logic        ph;
    logic        actQ;
    logic        phQ;
    logic        sDone;
    logic        sDoneQ;
    logic [17:0] mWord;
    logic [7:0]  mLen;
    logic [18:0] sWord;
    assign act = frameSync ^ pol;
    assign ph  = sclkOut ^ inv;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            actQ   <= 1'b0;
            phQ    <= 1'b0;
            mLen   <= 8'h00;
            sDoneQ <= 1'b0;
        end else begin
            actQ   <= act;
            phQ    <= ph;
            sDoneQ <= sDone;
            if (act && !actQ) begin
                mLen <= 8'h01;
            end else if (act) begin
                mLen <= mLen + 8'h01;
            end
            // Sample on the active edge, mid-way through the bit
            if (act && ph && !phQ) begin
                mWord <= {mWord[16:0], serialResultOutput};
            end
        end
    end
    always_ff @(posedge clk) begin
        linkDone <= (actQ && !act) || (sDone != sDoneQ);
        linkVal  <= (sDone != sDoneQ) ? {13'h0000, sWord}
                                      : {6'h00, mLen, mWord};
    end
    initial begin
        sclkIn      = 1'b0;
        chipSelectN = 1'b1;
        sDone       = 1'b0;
    end
    // Link side needs a few edges to see new mode and result
    always @(posedge slvGo) begin
        for (int i = 0; i < 23; i++) begin
            chipSelectN = (i < 4);
            #62.5 sclkIn = ~inv;
            #62.5 sclkIn = inv;
            if (i >= 4) begin
                sWord = {sWord[17:0], serialResultOutput};
            end
        end
        #40 chipSelectN = 1'b1;
        sDone = ~sDone;
    end
endmodule : asp_host_model

// File: tb/adc_serial_port_config_tb_top.sv
// Bench for the converter port: bus, shared pins, master and slave link
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
    $display("wrong value %s exp %h seen %h", n, e, s); end end
module adc_serial_port_config_tb_top;
    logic        clk;
    logic        rst;
    logic [3:0]  avsAddress;
    logic        avsRead;
    logic        avsWrite;
    logic [31:0] avsWritedata;
    logic [31:0] avsReaddata;
    logic        avsWaitrequest;
    logic [3:0]  cfg;
    logic [3:0]  parPin;
    logic [3:0]  parBitOut;
    logic [3:0]  parBitOeN;
    logic        codeSel;
    logic        hostSclk;
    logic        sclkOut;
    logic        sclkOeN;
    logic        chipSelectN;
    logic        serialResultOutput;
    logic        frameSync;
    logic        slvGo;
    logic        linkDone;
    logic [31:0] linkVal;
    logic [31:0] busQ[$];
    logic [31:0] linkQ[$];
    logic [17:0] lastCode;
    logic [17:0] smp;
    int          failures;
    int          compares;
    int          linkCnt;
    // Pins resolve from the DUT's enable alone: cfg when released, else parBitOut
    assign parPin = (parBitOeN & cfg) | (~parBitOeN & parBitOut);
    asp_serial_port dut (.clk(clk), .rst(rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .parBitIn(parPin), .parBitOut(parBitOut), .parBitOeN(parBitOeN),
        .outputCodingSelect(codeSel),
        .sclkIn(sclkOeN ? hostSclk : sclkOut), .sclkOut(sclkOut),
        .sclkOeN(sclkOeN), .chipSelectN(chipSelectN),
        .serialResultOutput(serialResultOutput), .frameSync(frameSync));
    asp_host_model host (.clk(clk), .rst(rst), .pol(cfg[1]), .inv(cfg[2]),
        .slvGo(slvGo), .sclkOut(sclkOut), .frameSync(frameSync),
        .serialResultOutput(serialResultOutput), .sclkIn(hostSclk),
        .chipSelectN(chipSelectN), .linkDone(linkDone), .linkVal(linkVal));
    function automatic logic [17:0] code(input logic [17:0] s, input logic c);
        return s ^ {~c, 17'h00000};
    endfunction : code
    task automatic results();
        if (failures == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic busCycle(input logic [3:0] a, input logic wr,
                            input logic [31:0] d);
        int n;
        @(posedge clk);
        avsAddress   <= a;
        avsWritedata <= d;
        avsWrite     <= wr;
        avsRead      <= ~wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            failures++;
            results();
        end
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
    endtask : busCycle
    task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
        busQ.push_back(e);
        busCycle(a, 1'b0, 32'h00000000);
    endtask : rdChk
    task automatic waitLink();
        int c0;
        c0 = linkCnt;
        for (int n = 0; n < 4000 && linkCnt == c0; n++) @(posedge clk);
        if (linkCnt == c0) begin
            failures++;
            results();
        end
    endtask : waitLink
    // Results are taken off the queues as they appear
    always @(posedge clk) begin
        if (avsRead && avsWaitrequest === 1'b0) begin
            `CHK("readdata", busQ.pop_front(), avsReaddata)
        end
        // Frame sync means nothing outside master mode, so its wiggles
        // while pins are remapped give the host false frame ends
        if (linkDone === 1'b1 && linkQ.size() != 0) begin
            `CHK("link frame", linkQ.pop_front(), linkVal)
            linkCnt++;
        end
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rst, avsAddress, avsRead, avsWrite, avsWritedata} = 39'h4000000000;
        {cfg, codeSel, slvGo, failures, compares, linkCnt} = '0;
        void'($urandom(38037));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdChk(asp_pkg::CTRL_OFS, 32'h0);
        rdChk(4'h1, 32'h0);
        rdChk(asp_pkg::STATUS_OFS, 32'h0);
        for (int m = 0; m < 3; m++) begin
            smp = 18'($urandom);
            codeSel <= m[0];
            busCycle(asp_pkg::CTRL_OFS, 1'b1, 32'(m));
            busCycle(asp_pkg::SAMPLE_OFS, 1'b1, {14'h0, smp});
            busCycle(asp_pkg::CTRL_OFS, 1'b1, 32'(m) | 32'h10);
            repeat (asp_pkg::CONV_CYC + 4) @(posedge clk);
            lastCode = code(smp, m[0]);
            rdChk(asp_pkg::RESULT_OFS, {14'h0, lastCode});
            @(negedge clk);
            `CHK("parBitOut", lastCode[9:6], parBitOut)
            `CHK("parBitOeN", 4'h0, parBitOeN)
        end
        for (int k = 0; k < 5; k++) begin
            cfg <= {k == 4, k[1], k[0], 1'b0};
            codeSel <= 1'($urandom);
            busCycle(asp_pkg::CTRL_OFS, 1'b1, 32'h3);
            repeat (3) @(posedge clk);
            @(negedge clk);
            `CHK("sclkOeN", 1'b0, sclkOeN)
            `CHK("parBitOeN", 4'hF, parBitOeN)
            `CHK("sclk idle", cfg[2], sclkOut)
            `CHK("sync idle", cfg[1], frameSync)
            smp = 18'($urandom);
            // Length field counts clk cycles with frame sync active
            linkQ.push_back(cfg[3]
                ? {14'(2 * asp_pkg::HALF_RDC * asp_pkg::RES_W),
                   lastCode}
                : {14'(2 * asp_pkg::HALF_RAC * asp_pkg::RES_W),
                   code(smp, codeSel)});
            busCycle(asp_pkg::SAMPLE_OFS, 1'b1, {14'h0, smp});
            busCycle(asp_pkg::CTRL_OFS, 1'b1, 32'h13);
            repeat (5) @(posedge clk);
            @(negedge clk);
            `CHK("sync in conv", cfg[3] ? ~cfg[1] : cfg[1], frameSync)
            waitLink();
            lastCode = code(smp, codeSel);
        end
        for (int s = 0; s < 2; s++) begin
            cfg <= {1'($urandom), s[0], 2'h1};
            repeat (6) @(posedge clk);
            `CHK("sclkOeN", 1'b1, sclkOeN)
            linkQ.push_back({13'h0, lastCode, cfg[3]});
            slvGo <= 1'b1;
            @(posedge clk);
            slvGo <= 1'b0;
            waitLink();
        end
        repeat (4) @(posedge clk);
        `CHK("pending", 0, busQ.size() + linkQ.size())
        results();
    end
endmodule : adc_serial_port_config_tb_top
